// *** src/kbd_tx_defs.svh ***
// timing counts, codes and field values of the keyboard transmitter
`ifndef KBD_TX_DEFS_SVH
`define KBD_TX_DEFS_SVH
`define KT_CLK_MHZ 40
`define KT_LOW_NS 41000
`define KT_HIGH_NS 35000
`define KT_PRE_NS 20000
`define KT_LOW_CYC ((`KT_LOW_NS * `KT_CLK_MHZ) / 1000)
`define KT_HIGH_CYC ((`KT_HIGH_NS * `KT_CLK_MHZ) / 1000)
`define KT_PRE_CYC ((`KT_PRE_NS * `KT_CLK_MHZ) / 1000)
`define KT_CHECK_MS 300
`define KT_TYPE_MS 500
`define KT_RPT_HZ 11
`define KT_CHECK_CYC (`KT_CHECK_MS * `KT_CLK_MHZ * 1000)
`define KT_TYPE_CYC (`KT_TYPE_MS * `KT_CLK_MHZ * 1000)
`define KT_RPT_CYC ((`KT_CLK_MHZ * 1000000) / `KT_RPT_HZ)
`define KT_SETTLE 16'h0004
`define KT_STOP_BIT 4'hA
`define KT_QDEPTH 5'h10
`define KT_CODE_DONE 8'hAA
`define KT_CODE_BREAK 8'hF0
`define KT_CODE_OVR 8'h00
`define KT_CODE_OVR1 8'hFF
`define KT_SET1_BRK 8'h80
`define KT_MODE1 2'h1
`define KT_MODE2 2'h2
`define KT_MODE3 2'h3
`define KT_ATTR_TYPE 2'h0
`define KT_ATTR_MAKE 2'h1
`define KT_ATTR_BRK 2'h2
`endif

// *** src/kbd_tx_pkg.sv ***
// types shared by the keyboard transmitter
package kbd_tx_pkg;
  typedef logic [1:0] mode_t;
  typedef logic [1:0] attr_t;
  typedef struct packed {
    logic valid;
    logic pressed;
    logic [7:0] code;
  } key_ev_s;
  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
  } line_drv_s;
  typedef enum logic [1:0] {TX_IDLE, TX_HIGH, TX_LOW} tx_state_e;
endpackage

// *** src/ps2_keyboard_transmitter.sv ***
// keyboard side of the two-wire link: code generation, queue, frame sender
`timescale 1ns/100ps
`include "kbd_tx_defs.svh"

module ps2_keyboard_transmitter
  import kbd_tx_pkg::*;
#(
  parameter int unsigned CHECK_CYC = `KT_CHECK_CYC,
  parameter int unsigned TYPE_CYC = `KT_TYPE_CYC,
  parameter int unsigned RPT_CYC = `KT_RPT_CYC,
  parameter logic [7:0] PAUSE_CODE = 8'h77,
  parameter logic [7:0] NET_LO = 8'h90,
  parameter logic [7:0] NET_HI = 8'h97
) (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // key matrix events
  input wire key_ev_s key_ev,
  // mode select
  input wire logic mode_we,
  input wire mode_t mode_wr,
  // per key attributes for mode 3
  input wire logic attr_we,
  input wire logic [7:0] attr_key,
  input wire attr_t attr_wr,
  // link lines
  input wire logic link_clk_i,
  input wire logic link_dat_i,
  output line_drv_s link_drv,
  // status
  output mode_t mode,
  output logic ready,
  output logic overrun
);

  localparam logic [15:0] LOW_C = 16'(`KT_LOW_CYC);
  localparam logic [15:0] HIGH_C = 16'(`KT_HIGH_CYC);
  localparam logic [15:0] PRE_C = 16'(`KT_PRE_CYC);
  localparam logic [24:0] CHECK_C = 25'(CHECK_CYC - 1);
  localparam logic [24:0] TYPE_C = 25'(TYPE_CYC - 1);
  localparam logic [24:0] RPT_C = 25'(RPT_CYC - 1);

  logic clk_s1_q, clk_s2_q, dat_s1_q, dat_s2_q;
  logic [24:0] chk_cnt_q;
  logic ready_q;
  mode_t mode_q;
  attr_t attr_q [256];
  logic [7:0] mem_q [16];
  logic [3:0] wr_q, rd_q;
  logic [4:0] cnt_q;
  logic drop_q;
  logic [7:0] rpt_key_q;
  logic rpt_on_q, rpt_arm_q;
  logic [24:0] rpt_cnt_q;
  tx_state_e tx_st_q;
  logic [15:0] tim_q;
  logic [3:0] bit_q;
  logic [10:0] shf_q;
  line_drv_s drv_q;
  logic [3:0] nfall_q;

  logic boot_done, rpt_fire, pop, abort, fits, ovr_w, ovr_new;
  logic is_pause, is_net, can_rpt;
  logic [1:0] push_n, wr_n;
  logic [7:0] b0, b1, ovr_code;
  attr_t key_attr;

  // link line synchronisers
  always_ff @(posedge clock) begin
    clk_s1_q <= link_clk_i;
    clk_s2_q <= clk_s1_q;
    dat_s1_q <= link_dat_i;
    dat_s2_q <= dat_s1_q;
  end

  // self check timer
  assign boot_done = !ready_q && (chk_cnt_q == CHECK_C);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chk_cnt_q <= 25'h0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      chk_cnt_q <= chk_cnt_q + 25'h1;
      if (boot_done) begin
        ready_q <= 1'b1;
      end
    end
  end

  // mode register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q <= `KT_MODE2;
    end else if (mode_we && mode_wr != 2'h0) begin
      mode_q <= mode_wr;
    end
  end

  a_mode_reset: assert property (@(posedge clock) $past(sys_rst) && !sys_rst |-> mode_q == `KT_MODE2) else $error("mode not 2 after reset");

  // per key attribute table
  for (genvar g = 0; g < 256; g++) begin : g_attr
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        attr_q[g] <= `KT_ATTR_TYPE;
      end else if (attr_we && attr_key == 8'(g)) begin
        attr_q[g] <= attr_wr;
      end
    end
  end

  // code generation
  always_comb begin
    key_attr = attr_q[key_ev.code];
    is_pause = key_ev.code == PAUSE_CODE;
    is_net = key_ev.code >= NET_LO && key_ev.code <= NET_HI;
    can_rpt = !is_pause && !is_net && (mode_q != `KT_MODE3 || key_attr == `KT_ATTR_TYPE);
    push_n = 2'h0;
    b0 = 8'h00;
    b1 = 8'h00;
    if (boot_done) begin
      push_n = 2'h1;
      b0 = `KT_CODE_DONE;
    end else if (key_ev.valid && ready_q) begin
      if (key_ev.pressed) begin
        if (!(mode_q == `KT_MODE3 && key_attr == `KT_ATTR_BRK)) begin
          push_n = 2'h1;
          b0 = key_ev.code;
        end
      end else if (!is_pause && !(mode_q == `KT_MODE3 && key_attr == `KT_ATTR_MAKE)) begin
        if (mode_q == `KT_MODE1) begin
          push_n = 2'h1;
          b0 = key_ev.code | `KT_SET1_BRK;
        end else begin
          push_n = 2'h2;
          b0 = `KT_CODE_BREAK;
          b1 = key_ev.code;
        end
      end
    end else if (rpt_fire && cnt_q == 5'h0) begin
      push_n = 2'h1;
      b0 = rpt_key_q;
    end
  end

  a_pause_make: assert property (@(posedge clock) disable iff (sys_rst) key_ev.valid && !key_ev.pressed && ready_q && key_ev.code == PAUSE_CODE |-> push_n == 2'h0) else $error("pause key sent a break");

  // typematic repeat of newest key
  assign rpt_fire = rpt_on_q && (rpt_cnt_q == (rpt_arm_q ? RPT_C : TYPE_C));
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rpt_on_q <= 1'b0;
      rpt_arm_q <= 1'b0;
      rpt_cnt_q <= 25'h0;
      rpt_key_q <= 8'h00;
    end else if (key_ev.valid && ready_q && key_ev.pressed) begin
      rpt_on_q <= can_rpt;
      rpt_arm_q <= 1'b0;
      rpt_cnt_q <= 25'h0;
      rpt_key_q <= key_ev.code;
    end else if (key_ev.valid && !key_ev.pressed && key_ev.code == rpt_key_q) begin
      rpt_on_q <= 1'b0;
    end else if (rpt_fire) begin
      rpt_arm_q <= 1'b1;
      rpt_cnt_q <= 25'h0;
    end else if (rpt_on_q) begin
      rpt_cnt_q <= rpt_cnt_q + 25'h1;
    end
  end

  // scan code queue
  always_comb begin
    ovr_code = (mode_q == `KT_MODE1) ? `KT_CODE_OVR1 : `KT_CODE_OVR;
    fits = ({3'h0, push_n} <= (`KT_QDEPTH - cnt_q));
    wr_n = (push_n != 2'h0 && !drop_q && fits) ? push_n : 2'h0;
    ovr_w = push_n != 2'h0 && !drop_q && !fits;
    ovr_new = ovr_w && cnt_q != `KT_QDEPTH;
  end

  always_ff @(posedge clock) begin
    if (wr_n != 2'h0) begin
      mem_q[wr_q] <= b0;
      if (wr_n == 2'h2) begin
        mem_q[4'(wr_q + 4'h1)] <= b1;
      end
    end else if (ovr_new) begin
      mem_q[wr_q] <= ovr_code;
    end else if (ovr_w) begin
      mem_q[4'(wr_q - 4'h1)] <= ovr_code;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      cnt_q <= 5'h0;
      drop_q <= 1'b0;
    end else begin
      wr_q <= wr_q + {2'h0, wr_n} + {3'h0, ovr_new};
      rd_q <= rd_q + {3'h0, pop};
      cnt_q <= cnt_q + {3'h0, wr_n} + {4'h0, ovr_new} - {4'h0, pop};
      if (ovr_w) begin
        drop_q <= 1'b1;
      end else if (cnt_q == 5'h0) begin
        drop_q <= 1'b0;
      end
    end
  end

  a_q_bound: assert property (@(posedge clock) disable iff (sys_rst) cnt_q <= `KT_QDEPTH) else $error("queue count above depth");
  a_first_done: assert property (@(posedge clock) disable iff (sys_rst) $rose(ready_q) |-> cnt_q == 5'h1 && mem_q[rd_q] == `KT_CODE_DONE) else $error("completion code missing");
  a_break_pair: assert property (@(posedge clock) disable iff (sys_rst) wr_n == 2'h2 |=> mem_q[$past(wr_q)] == `KT_CODE_BREAK && mem_q[4'($past(wr_q) + 4'h1)] == $past(key_ev.code)) else $error("break pair wrong");

  // frame sender
  assign pop = tx_st_q == TX_LOW && tim_q == LOW_C - 16'h1 && bit_q == `KT_STOP_BIT;
  assign abort = tx_st_q == TX_HIGH && bit_q == `KT_STOP_BIT && tim_q >= `KT_SETTLE && !clk_s2_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_st_q <= TX_IDLE;
      tim_q <= 16'h0;
      bit_q <= 4'h0;
      shf_q <= 11'h7FF;
      drv_q <= '0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          drv_q <= '0;
          if (ready_q && cnt_q != 5'h0 && clk_s2_q && dat_s2_q) begin
            tim_q <= tim_q + 16'h1;
            if (tim_q == PRE_C - 16'h1) begin
              shf_q <= {1'b1, ~^mem_q[rd_q], mem_q[rd_q], 1'b0};
              drv_q.dat_oe <= 1'b1;
              bit_q <= 4'h0;
              tim_q <= 16'h0;
              tx_st_q <= TX_HIGH;
            end
          end else begin
            tim_q <= 16'h0;
          end
        end
        TX_HIGH: begin
          tim_q <= tim_q + 16'h1;
          if (abort) begin
            drv_q <= '0;
            tim_q <= 16'h0;
            tx_st_q <= TX_IDLE;
          end else if (tim_q == HIGH_C - 16'h1) begin
            drv_q.clk_oe <= 1'b1;
            tim_q <= 16'h0;
            tx_st_q <= TX_LOW;
          end
        end
        TX_LOW: begin
          tim_q <= tim_q + 16'h1;
          if (tim_q == LOW_C - 16'h1) begin
            drv_q.clk_oe <= 1'b0;
            tim_q <= 16'h0;
            if (bit_q == `KT_STOP_BIT) begin
              drv_q.dat_oe <= 1'b0;
              tx_st_q <= TX_IDLE;
            end else begin
              bit_q <= bit_q + 4'h1;
              shf_q <= {1'b1, shf_q[10:1]};
              drv_q.dat_oe <= ~shf_q[1];
              tx_st_q <= TX_HIGH;
            end
          end
        end
        default: begin
          tx_st_q <= TX_IDLE;
        end
      endcase
    end
  end

  // host low on clock is watched in idle and, within a frame, only in the high phase of the stop bit, far inside 60 us
  a_inhibit_hold: assert property (@(posedge clock) disable iff (sys_rst) tx_st_q == TX_IDLE && !clk_s2_q |=> tx_st_q == TX_IDLE) else $error("frame began while inhibited");
  a_abort_keep: assert property (@(posedge clock) disable iff (sys_rst) abort |=> tx_st_q == TX_IDLE && cnt_q >= $past(cnt_q)) else $error("aborted byte lost");
  a_low_len: assert property (@(posedge clock) disable iff (sys_rst) $fell(drv_q.clk_oe) && !$past(sys_rst) |-> $past(tim_q) == LOW_C - 16'h1 && $past(tx_st_q) == TX_LOW) else $error("clock low length wrong");
  a_high_len: assert property (@(posedge clock) disable iff (sys_rst) $rose(drv_q.clk_oe) |-> $past(tim_q) == HIGH_C - 16'h1) else $error("clock high length wrong");
  a_start_low: assert property (@(posedge clock) disable iff (sys_rst) tx_st_q == TX_HIGH && bit_q == 4'h0 |-> drv_q.dat_oe) else $error("start bit not low");
  a_idle_free: assert property (@(posedge clock) disable iff (sys_rst) tx_st_q == TX_IDLE |-> !drv_q.clk_oe && !drv_q.dat_oe) else $error("line driven between frames");
  a_pre_wait: assert property (@(posedge clock) disable iff (sys_rst) tx_st_q == TX_IDLE ##1 tx_st_q == TX_HIGH |-> $past(tim_q) == PRE_C - 16'h1 && $past(clk_s2_q)) else $error("idle high time too short");

  // clock falls per frame, for checking
  always_ff @(posedge clock) begin
    if (sys_rst || tx_st_q == TX_IDLE) begin
      nfall_q <= 4'h0;
    end else if (tx_st_q == TX_HIGH && tim_q == HIGH_C - 16'h1 && !abort) begin
      nfall_q <= nfall_q + 4'h1;
    end
  end

  a_frame_bits: assert property (@(posedge clock) disable iff (sys_rst) pop |-> nfall_q == 4'hB) else $error("frame not eleven clocks");

  assign link_drv = drv_q;
  assign mode = mode_q;
  assign ready = ready_q;
  assign overrun = drop_q;

endmodule // ps2_keyboard_transmitter

// *** dv/kbd_host_model.sv ***
// host side of the link: pull-ups, inhibit and frame receiver
`timescale 1ns/100ps
module kbd_host_model
  import kbd_tx_pkg::*;
(
  // system
  input wire logic clock,
  // link
  input wire line_drv_s link_drv,
  input wire logic inhibit,
  output logic link_clk_i,
  output logic link_dat_i,
  // received data
  output logic keyboard_interrupt_request = 1'b0,
  output logic [7:0] rx_byte = 8'h00,
  output int phase_errs = 0,
  output int frame_errs = 0
);
  logic clk_q = 1'b1;
  logic [10:0] sh = 11'h000;
  int run = 0;
  int idle = 0;
  int nbits = 0;
  // clock low while either party pulls it, data low while the keyboard pulls it
  assign link_clk_i = !(link_drv.clk_oe | inhibit);
  assign link_dat_i = !link_drv.dat_oe;
  always @(posedge clock) begin
    keyboard_interrupt_request <= 1'b0;
    clk_q <= link_clk_i;
    run <= (link_clk_i != clk_q) ? 1 : run + 1;
    idle <= (link_clk_i && link_dat_i) ? idle + 1 : 0;
    if (nbits == 0 && link_clk_i && !link_dat_i && idle > 0 && idle < 800) begin
      phase_errs <= phase_errs + 1;
    end
    if (clk_q && !link_clk_i && !inhibit) begin
      if (nbits > 0 && run != 1400) begin
        phase_errs <= phase_errs + 1;
      end
      sh <= {link_dat_i, sh[10:1]};
      nbits <= nbits + 1;
    end
    if (!clk_q && link_clk_i && nbits > 0) begin
      if (run != 1640) begin
        phase_errs <= phase_errs + 1;
      end
      if (nbits == 11) begin
        nbits <= 0;
        rx_byte <= sh[8:1];
        keyboard_interrupt_request <= 1'b1;
        if (sh[0] || !sh[10] || !(^sh[9:1])) begin
          frame_errs <= frame_errs + 1;
        end
      end
    end
  end
endmodule // kbd_host_model

// *** dv/ps2_keyboard_transmitter_bench.sv ***
// self-checking bench of the keyboard transmitter
`timescale 1ns/100ps
module ps2_keyboard_transmitter_bench
  import kbd_tx_pkg::*;
;
  typedef struct packed {
    mode_t wr;
    mode_t exp;
  } mode_row_s;
  localparam int LIMIT = 100000;
  mode_row_s rows [5] = '{'{2'h1, 2'h1}, '{2'h0, 2'h1}, '{2'h3, 2'h3}, '{2'h2, 2'h2},
    '{2'h3, 2'h3}};
  logic clock;
  logic sys_rst;
  key_ev_s key_ev;
  logic mode_we;
  mode_t mode_wr;
  logic attr_we;
  logic [7:0] attr_key;
  attr_t attr_wr;
  logic link_clk_i;
  logic link_dat_i;
  line_drv_s link_drv;
  mode_t mode;
  logic ready;
  logic overrun;
  logic inhibit;
  logic irq;
  logic [7:0] rx_byte;
  int phase_errs;
  int frame_errs;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int t0;

  ps2_keyboard_transmitter #(.CHECK_CYC(50), .TYPE_CYC(400), .RPT_CYC(100),
    .PAUSE_CODE(8'h77)) dut (
    .clock(clock), .sys_rst(sys_rst), .key_ev(key_ev), .mode_we(mode_we),
    .mode_wr(mode_wr), .attr_we(attr_we), .attr_key(attr_key), .attr_wr(attr_wr),
    .link_clk_i(link_clk_i), .link_dat_i(link_dat_i), .link_drv(link_drv),
    .mode(mode), .ready(ready), .overrun(overrun));
  kbd_host_model host (
    .clock(clock), .link_drv(link_drv), .inhibit(inhibit), .link_clk_i(link_clk_i),
    .link_dat_i(link_dat_i), .keyboard_interrupt_request(irq), .rx_byte(rx_byte),
    .phase_errs(phase_errs), .frame_errs(frame_errs));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one press event of a key
  task automatic press(input logic [7:0] c);
    key_ev <= '{valid: 1'b1, pressed: 1'b1, code: c};
    @(posedge clock);
    key_ev <= '0;
  endtask

  task automatic get(input logic [7:0] exp);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 40000) begin
      @(posedge clock);
      n++;
    end
    check(16'(rx_byte), 16'(exp));
    @(posedge clock);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    sys_rst = 1'b1;
    key_ev = '0;
    mode_we = 1'b0;
    mode_wr = 2'h0;
    attr_we = 1'b0;
    attr_key = 8'h00;
    attr_wr = 2'h0;
    inhibit = 1'b1;
    tick(6);
    check(16'(link_drv), 16'h0000);
    check(16'(mode), 16'h0002);
    check(16'(ready), 16'h0000);
    sys_rst <= 1'b0;
    t0 = cycles;
    press(8'h55);
    foreach (rows[i]) begin
      mode_we <= 1'b1;
      mode_wr <= rows[i].wr;
      @(posedge clock);
      mode_we <= 1'b0;
      @(posedge clock);
      @(negedge clock);
      check(16'(mode), 16'(rows[i].exp));
      @(posedge clock);
    end
    $display("end of test mode select");
    attr_we <= 1'b1;
    attr_key <= 8'h1C;
    attr_wr <= 2'h1;
    @(posedge clock);
    attr_we <= 1'b0;
    while (ready !== 1'b1 && cycles - t0 < 100) @(posedge clock);
    check(16'((cycles - t0) inside {[49:53]}), 16'h0001);
    press(8'h1C);
    tick(2000);
    @(negedge clock);
    check(16'(link_drv), 16'h0000);
    @(posedge clock);
    inhibit <= 1'b0;
    get(8'hAA);
    get(8'h1C);
    tick(1500);
    @(negedge clock);
    check(16'(link_drv), 16'h0000);
    check(16'(phase_errs), 16'h0000);
    check(16'(frame_errs), 16'h0000);
    $display("end of test frames");
    @(posedge clock);
    inhibit <= 1'b1;
    tick(4);
    key_ev <= '{valid: 1'b1, pressed: 1'b1, code: 8'h1C};
    tick(16);
    key_ev <= '0;
    @(negedge clock);
    check(16'(overrun), 16'h0000);
    @(posedge clock);
    press(8'h1C);
    tick(2);
    @(negedge clock);
    check(16'(overrun), 16'h0001);
    $display("end of test overrun");
    // mid-run reset, then make and break codes filling a fresh queue
    @(posedge clock);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    @(negedge clock);
    check(16'(link_drv), 16'h0000);
    check(16'(mode), 16'h0002);
    check(16'(ready), 16'h0000);
    check(16'(overrun), 16'h0000);
    repeat (60) @(posedge clock);
    check(16'(ready), 16'h0001);
    key_ev <= '{valid: 1'b1, pressed: 1'b1, code: 8'h2A};
    tick(12);
    key_ev <= '{valid: 1'b1, pressed: 1'b0, code: 8'h77};
    @(posedge clock);
    key_ev <= '{valid: 1'b1, pressed: 1'b0, code: 8'h2A};
    @(posedge clock);
    key_ev <= '0;
    @(negedge clock);
    check(16'(overrun), 16'h0000);
    @(posedge clock);
    key_ev <= '{valid: 1'b1, pressed: 1'b0, code: 8'h2A};
    @(posedge clock);
    key_ev <= '0;
    @(negedge clock);
    check(16'(overrun), 16'h0001);
    $display("end of test reset and breaks");
    end_sim();
  end
endmodule // ps2_keyboard_transmitter_bench
